// ### core/alm_monitor.sv
// Dual alarm monitor: register file, two alarm channels, indicator pin drive.
// Assumes frames and sample strobes arrive from logic on core_clk_i.
// Notes on behaviour
// - Two alarm channels run independently, each with its own threshold, polarity and source.
// - Static mode compares the source word with the signed threshold, top bit as sign.
// - The threshold is read in the same signed format and scale as the selected word.
// - Dynamic mode compares the change over the programmed sample count with the threshold.
// - The sample count is an 8-bit value with upper bits unused, and zero acts as one.
// - Each channel's alarm shows as a flag in bits 9:8 of the diagnostic status.
// - Channel 2's selector: 0 off, 1-3 rate, 4-6 accel, 7/9/10 field, 11 pressure, 12 temp.
// - Channel 1's selector sits in control bits 11:8 with the same codes.
// - Control bits 7 and 6 pick dynamic mode for channel 2 and channel 1.
// - Control bits 5 and 4 make channel 2 and 1 trigger above the threshold, else below.
// - Control bit 3 makes both channels watch filtered words instead of raw ones.
// - Control bit 2 enables the indicator pin; when clear the pin is left undriven.
// - Control bit 1 makes the indicator active high, else active low.
// - Control bit 0 routes the indicator to the second I/O pin, else the first.
`timescale 1ns/1ps

module alm_monitor
    import alm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Host frames
    input wire logic frame_valid_i,
    input wire alm_frame_t frame_i,
    output logic [15:0] read_data_o,
    output logic read_valid_o,
    // Sensor words
    input wire logic sample_i,
    input wire alm_words_t raw_words_i,
    input wire alm_words_t filt_words_i,
    // Alarm state
    output logic [1:0] alarm_flags_o,
    // Indicator pins
    output alm_pin_t digital_io_first_o,
    output alm_pin_t digital_io_second_o
);

    logic [15:0] threshold [2];
    logic [7:0] sample_count [2];
    logic [15:0] alarm_control;
    logic [1:0] alarm_state;
    logic [15:0] diagnostic_status;
    logic wr_en;
    logic rd_en;
    logic [6:0] rd_addr;
    logic ind_level;
    alm_words_t src_words;

    assign wr_en = frame_valid_i && frame_i.write;
    assign rd_en = frame_valid_i && !frame_i.write;
    assign rd_addr = {frame_i.addr[6:1], 1'b0};

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            alarm_control <= ALM_CONTROL_RESET;
        end
        else if (wr_en && frame_i.addr == ALM_ADDR_CONTROL)
        begin
            alarm_control[7:0] <= frame_i.data;
        end
        else if (wr_en && frame_i.addr == (ALM_ADDR_CONTROL | 7'h01))
        begin
            alarm_control[15:8] <= frame_i.data;
        end
    end

    always_comb
    begin
        diagnostic_status = 16'h0000;
        diagnostic_status[ALM_DIAG_ONE_BIT] = alarm_state[0];
        diagnostic_status[ALM_DIAG_TWO_BIT] = alarm_state[1];
    end

    // Read answer strobe
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            read_valid_o <= 1'b0;
        end
        else
        begin
            read_valid_o <= rd_en;
        end
    end

    // Register reads
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            read_data_o <= 16'h0000;
        end
        else
        begin
            if (rd_en)
            begin
                unique case (rd_addr)
                    ALM_ADDR_ONE_THRESHOLD: read_data_o <= threshold[0];
                    ALM_ADDR_TWO_THRESHOLD: read_data_o <= threshold[1];
                    ALM_ADDR_ONE_SAMPLE_COUNT: read_data_o <= {8'h00, sample_count[0]};
                    ALM_ADDR_TWO_SAMPLE_COUNT: read_data_o <= {8'h00, sample_count[1]};
                    ALM_ADDR_CONTROL: read_data_o <= alarm_control;
                    ALM_ADDR_DIAG_STATUS: read_data_o <= diagnostic_status;
                    default: read_data_o <= 16'h0000;
                endcase
            end
        end
    end

    assign src_words = alarm_control[ALARM_CONTROL_FILTERED] ? filt_words_i : raw_words_i;

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        localparam logic [6:0] THR_ADDR = (ch == 0) ? ALM_ADDR_ONE_THRESHOLD
                                                     : ALM_ADDR_TWO_THRESHOLD;
        localparam logic [6:0] CNT_ADDR = (ch == 0) ? ALM_ADDR_ONE_SAMPLE_COUNT
                                                     : ALM_ADDR_TWO_SAMPLE_COUNT;
        localparam int SRC_LSB = (ch == 0) ? ALARM_CONTROL_SRC_ONE_LSB : ALARM_CONTROL_SRC_TWO_LSB;
        localparam int DYN_BIT = (ch == 0) ? ALARM_CONTROL_DYN_ONE : ALARM_CONTROL_DYN_TWO;
        localparam int POL_BIT = (ch == 0) ? ALARM_CONTROL_POL_ONE : ALARM_CONTROL_POL_TWO;

        logic [3:0] sel;
        logic src_on;
        logic [3:0] src_idx;
        logic signed [16:0] word;
        logic signed [16:0] thr;
        logic signed [16:0] delta;
        logic signed [16:0] metric;
        logic [7:0] span;
        logic [15:0] hist [ALM_HIST_DEPTH];
        logic [7:0] wptr;
        logic [7:0] fill;
        logic [7:0] old_idx;
        logic next_alarm;

        // Threshold writes
        always_ff @(posedge core_clk_i)
        begin
            if (reset_i)
            begin
                threshold[ch] <= ALM_THRESHOLD_RESET;
            end
            else if (wr_en && frame_i.addr == THR_ADDR)
            begin
                threshold[ch][7:0] <= frame_i.data;
            end
            else if (wr_en && frame_i.addr == (THR_ADDR | 7'h01))
            begin
                threshold[ch][15:8] <= frame_i.data;
            end
        end

        // Only the low byte is stored
        always_ff @(posedge core_clk_i)
        begin
            if (reset_i)
            begin
                sample_count[ch] <= ALM_SAMPLE_COUNT_RESET;
            end
            else if (wr_en && frame_i.addr == CNT_ADDR)
            begin
                sample_count[ch] <= frame_i.data;
            end
        end

        assign sel = alarm_control[SRC_LSB +: 4];

        always_comb
        begin
            src_on = 1'b1;
            src_idx = 4'h0;
            unique case (sel)
                ALM_SRC_RATE_X: src_idx = 4'h0;
                ALM_SRC_RATE_Y: src_idx = 4'h1;
                ALM_SRC_RATE_Z: src_idx = 4'h2;
                ALM_SRC_ACCEL_X: src_idx = 4'h3;
                ALM_SRC_ACCEL_Y: src_idx = 4'h4;
                ALM_SRC_ACCEL_Z: src_idx = 4'h5;
                ALM_SRC_FIELD_X: src_idx = 4'h6;
                ALM_SRC_FIELD_Y: src_idx = 4'h7;
                ALM_SRC_FIELD_Z: src_idx = 4'h8;
                ALM_SRC_PRESSURE: src_idx = 4'h9;
                ALM_SRC_TEMP: src_idx = 4'ha;
                default: src_on = 1'b0;
            endcase
        end

        // Threshold in the word's signed format
        assign word = {src_words[src_idx][15], src_words[src_idx]};
        assign thr = {threshold[ch][15], threshold[ch]};

        assign span = (sample_count[ch] == 8'h00) ? 8'h01 : sample_count[ch];
        assign old_idx = wptr - span;

        assign delta = word - {hist[old_idx][15], hist[old_idx]};

        // Sample history
        always_ff @(posedge core_clk_i)
        begin
            if (sample_i)
            begin
                hist[wptr] <= src_words[src_idx];
            end
        end

        // History pointer and fill level
        always_ff @(posedge core_clk_i)
        begin
            if (reset_i)
            begin
                wptr <= 8'h00;
                fill <= 8'h00;
            end
            else if (sample_i)
            begin
                wptr <= wptr + 8'h01;
                if (fill != ALM_FILL_MAX)
                begin
                    fill <= fill + 8'h01;
                end
            end
        end

        assign metric = alarm_control[DYN_BIT] ? delta : word;

        always_comb
        begin
            next_alarm = 1'b0;
            if (src_on && (!alarm_control[DYN_BIT] || fill >= span))
            begin
                next_alarm = alarm_control[POL_BIT] ? (metric > thr) : (metric < thr);
            end
        end

        always_ff @(posedge core_clk_i)
        begin
            if (reset_i)
            begin
                alarm_state[ch] <= 1'b0;
            end
            else if (sample_i || !src_on)
            begin
                alarm_state[ch] <= next_alarm;
            end
        end
    end

    assign alarm_flags_o = alarm_state;

    assign ind_level = (|alarm_state) ~^ alarm_control[ALARM_CONTROL_IND_HIGH];

    // First indicator pin
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            digital_io_first_o <= '0;
        end
        else
        begin
            digital_io_first_o.out <= ind_level;
            digital_io_first_o.oe <= alarm_control[ALARM_CONTROL_IND_EN]
                                     && !alarm_control[ALARM_CONTROL_IND_SECOND];
        end
    end

    // Second indicator pin
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            digital_io_second_o <= '0;
        end
        else
        begin
            digital_io_second_o.out <= ind_level;
            digital_io_second_o.oe <= alarm_control[ALARM_CONTROL_IND_EN]
                                      && alarm_control[ALARM_CONTROL_IND_SECOND];
        end
    end

endmodule

// ### core/alm_pkg.sv
// Package for the dual alarm monitor: register map, field positions, types.
// Assumes a single core clock and a host that sends 16-bit byte-write frames.
package alm_pkg;

    // Register byte addresses
    localparam logic [6:0] ALM_ADDR_ONE_THRESHOLD = 7'h40;
    localparam logic [6:0] ALM_ADDR_TWO_THRESHOLD = 7'h42;
    localparam logic [6:0] ALM_ADDR_ONE_SAMPLE_COUNT = 7'h44;
    localparam logic [6:0] ALM_ADDR_TWO_SAMPLE_COUNT = 7'h46;
    localparam logic [6:0] ALM_ADDR_CONTROL = 7'h48;
    localparam logic [6:0] ALM_ADDR_DIAG_STATUS = 7'h3c;

    // Reset values
    localparam logic [15:0] ALM_THRESHOLD_RESET = 16'h0000;
    localparam logic [7:0] ALM_SAMPLE_COUNT_RESET = 8'h00;
    localparam logic [15:0] ALM_CONTROL_RESET = 16'h0000;

    // Frame fields
    localparam int ALM_FRAME_WRITE_BIT = 15;
    localparam int ALM_FRAME_ADDR_LSB = 8;

    // Control field positions
    localparam int ALARM_CONTROL_SRC_TWO_LSB = 12;
    localparam int ALARM_CONTROL_SRC_ONE_LSB = 8;
    localparam int ALARM_CONTROL_DYN_TWO = 7;
    localparam int ALARM_CONTROL_DYN_ONE = 6;
    localparam int ALARM_CONTROL_POL_TWO = 5;
    localparam int ALARM_CONTROL_POL_ONE = 4;
    localparam int ALARM_CONTROL_FILTERED = 3;
    localparam int ALARM_CONTROL_IND_EN = 2;
    localparam int ALARM_CONTROL_IND_HIGH = 1;
    localparam int ALARM_CONTROL_IND_SECOND = 0;

    // Diagnostic flag positions
    localparam int ALM_DIAG_ONE_BIT = 8;
    localparam int ALM_DIAG_TWO_BIT = 9;

    // Sources and history
    localparam int ALM_NUM_SOURCES = 11;
    localparam int ALM_HIST_DEPTH = 256;
    localparam logic [7:0] ALM_FILL_MAX = 8'hff;

    // Source selector codes
    typedef enum logic [3:0] {
        ALM_SRC_OFF = 4'h0,
        ALM_SRC_RATE_X = 4'h1,
        ALM_SRC_RATE_Y = 4'h2,
        ALM_SRC_RATE_Z = 4'h3,
        ALM_SRC_ACCEL_X = 4'h4,
        ALM_SRC_ACCEL_Y = 4'h5,
        ALM_SRC_ACCEL_Z = 4'h6,
        ALM_SRC_FIELD_X = 4'h7,
        ALM_SRC_FIELD_Y = 4'h9,
        ALM_SRC_FIELD_Z = 4'ha,
        ALM_SRC_PRESSURE = 4'hb,
        ALM_SRC_TEMP = 4'hc
    } alm_src_t;

    // Sensor word set, index 0..10 in selector order
    typedef logic [ALM_NUM_SOURCES-1:0][15:0] alm_words_t;

    // Host frame
    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [7:0] data;
    } alm_frame_t;

    // Pin drive
    typedef struct packed {
        logic out;
        logic oe;
    } alm_pin_t;

endpackage

// ### sim/alm_monitor_sva.sv
// Port checker for the dual alarm monitor.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module alm_monitor_sva
    import alm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic frame_valid_i,
    input wire alm_frame_t frame_i,
    input wire logic [15:0] read_data_o,
    input wire logic read_valid_o,
    input wire logic sample_i,
    input wire logic [1:0] alarm_flags_o,
    input wire alm_pin_t digital_io_first_o,
    input wire alm_pin_t digital_io_second_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    a_read_answer: assert property (frame_valid_i && !frame_i.write |=> read_valid_o)
        else $error("read frame got no answer");
    a_read_cause: assert property (read_valid_o
        |-> $past(frame_valid_i) && !$past(frame_i.write))
        else $error("read answer without read frame");
    a_data_hold: assert property (!read_valid_o |-> $stable(read_data_o))
        else $error("read data moved without answer");
    a_reset_quiet: assert property (disable iff (1'b0) reset_i |=> alarm_flags_o == 2'b00
        && !read_valid_o && !digital_io_first_o.oe && !digital_io_second_o.oe)
        else $error("outputs active after reset");
    a_flag_one_cause: assert property ($rose(alarm_flags_o[0]) |-> $past(sample_i))
        else $error("channel one flag rose without sample");
    a_flag_two_cause: assert property (!sample_i && !alarm_flags_o[1]
        |=> !alarm_flags_o[1])
        else $error("channel two flag rose without sample");
    a_oe_stable: assert property (!frame_valid_i ##1 !frame_valid_i |=>
        $stable(digital_io_first_o.oe) && $stable(digital_io_second_o.oe))
        else $error("pin enable moved without a write");
    a_one_pin: assert property (!(digital_io_first_o.oe && digital_io_second_o.oe))
        else $error("both indicator pins driven");
endmodule
bind alm_monitor alm_monitor_sva alm_monitor_sva_inst (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .frame_valid_i(frame_valid_i), .frame_i(frame_i),
    .read_data_o(read_data_o), .read_valid_o(read_valid_o), .sample_i(sample_i),
    .alarm_flags_o(alarm_flags_o), .digital_io_first_o(digital_io_first_o),
    .digital_io_second_o(digital_io_second_o));

// ### sim/alm_host.sv
// Host model: sends byte frames and reads words on the register port.
// Assumes a read answer comes one cycle after the frame is taken.
`timescale 1ns/1ps
module alm_host
    import alm_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Frames
    output alm_frame_t frame_o,
    output logic frame_valid_o,
    // Read answer
    input wire logic [15:0] read_data_i,
    input wire logic read_valid_i
);
    initial
    begin
        frame_o = '0;
        frame_valid_o = 1'b0;
    end
    task automatic put(input alm_frame_t f);
        @(posedge core_clk_i);
        #2;
        frame_valid_o = 1'b1;
        frame_o = f;
    endtask
    // Released port shows inverted data
    task automatic idle();
        @(posedge core_clk_i);
        #2;
        frame_valid_o = 1'b0;
        frame_o = ~frame_o;
    endtask
    task automatic write16(input logic [6:0] a, input logic [15:0] d);
        put({1'b1, a, d[7:0]});
        put({1'b1, a | 7'h01, d[15:8]});
        idle();
    endtask
    task automatic read16(input logic [6:0] a, output logic [15:0] d, output logic got);
        put({1'b0, a, 8'h00});
        idle();
        got = 1'b0;
        d = '0;
        for (int i = 0; i < 4 && !got; i++)
        begin
            got = (read_valid_i === 1'b1);
            d = read_data_i;
            if (!got)
            begin
                @(posedge core_clk_i);
                #2;
            end
        end
    endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the dual alarm monitor.
// Assumes the host model drives frames; the bench drives samples.
`timescale 1ns/1ps
module tb;
    import alm_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sample = 1'b0;
    alm_words_t raw = '0;
    alm_words_t filt = '0;
    alm_words_t r;
    alm_words_t f;
    logic frame_valid;
    alm_frame_t frame;
    logic [15:0] read_data;
    logic read_valid;
    logic [1:0] flags;
    alm_pin_t pin_a;
    alm_pin_t pin_b;
    int mismatches = 0;
    int num_checks = 0;
    logic [15:0] rd;
    logic [15:0] ctrl;
    logic [15:0] thr [2];
    logic [3:0] c [2];
    logic [1:0] e;
    logic [3:0] codes [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc};
    int spans [3] = '{0, 1, 4};
    int keff;
    int step;
    always #12.5 core_clk = ~core_clk;
    alm_monitor alm_monitor_inst (.core_clk_i(core_clk), .reset_i(reset),
        .frame_valid_i(frame_valid), .frame_i(frame), .read_data_o(read_data),
        .read_valid_o(read_valid), .sample_i(sample), .raw_words_i(raw), .filt_words_i(filt),
        .alarm_flags_o(flags), .digital_io_first_o(pin_a), .digital_io_second_o(pin_b));
    alm_host alm_host_inst (.core_clk_i(core_clk), .frame_o(frame), .frame_valid_o(frame_valid),
        .read_data_i(read_data), .read_valid_i(read_valid));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic rd16(input logic [6:0] a);
        logic got;
        alm_host_inst.read16(a, rd, got);
        if (!got)
        begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic smp(input alm_words_t rw, input alm_words_t fw);
        @(posedge core_clk);
        #2;
        sample = 1'b1;
        raw = rw;
        filt = fw;
        @(posedge core_clk);
        #2;
        sample = 1'b0;
        raw = ~rw;
        filt = ~fw;
    endtask
    function automatic logic hit(input logic [15:0] v, input logic [15:0] t, input logic pol);
        return pol ? ($signed(v) > $signed(t)) : ($signed(v) < $signed(t));
    endfunction
    function automatic int idx(input logic [3:0] cd);
        return (cd < 4'h8) ? cd - 1 : cd - 2;
    endfunction
    initial
    begin
        void'($urandom(14764));
        repeat (10) @(posedge core_clk);
        #2;
        reset = 1'b0;
        for (int a = 'h40; a < 'h4c; a += 2)
        begin
            rd16(7'(a));
            check("reset value", rd, 16'h0000);
        end
        step = $urandom;
        alm_host_inst.write16(ALM_ADDR_TWO_SAMPLE_COUNT, 16'(step));
        rd16(ALM_ADDR_TWO_SAMPLE_COUNT);
        check("count upper", rd, {8'h00, 8'(step)});
        $display("test registers done");
        for (int n = 0; n < 60; n++)
        begin
            for (int w = 0; w < 11; w++)
            begin
                r[w] = $urandom;
                f[w] = $urandom;
            end
            ctrl = 16'($urandom) & 16'h003f;
            for (int k = 0; k < 2; k++)
            begin
                c[k] = (n % 7 == k) ? 4'h0 : codes[$urandom % 11];
                // every fifth pass, threshold equal to the selected raw word
                thr[k] = (n % 5 == 1 && c[k] != 4'h0) ? r[idx(c[k])] : 16'($urandom);
                alm_host_inst.write16(k ? ALM_ADDR_TWO_THRESHOLD : ALM_ADDR_ONE_THRESHOLD,
                    thr[k]);
                e[k] = (c[k] != 4'h0)
                    && hit(ctrl[3] ? f[idx(c[k])] : r[idx(c[k])], thr[k], ctrl[4 + k]);
            end
            ctrl[15:8] = {c[1], c[0]};
            alm_host_inst.write16(ALM_ADDR_CONTROL, ctrl);
            smp(r, f);
            check("flags", {14'h0, flags}, {14'h0, e});
            check("oe first", {15'h0, pin_a.oe}, {15'h0, ctrl[2] & ~ctrl[0]});
            check("oe second", {15'h0, pin_b.oe}, {15'h0, ctrl[2] & ctrl[0]});
            // Pins follow the flags one cycle later
            @(posedge core_clk);
            #2;
            if (ctrl[2])
                check("pin out", {15'h0, ctrl[0] ? pin_b.out : pin_a.out},
                    {15'h0, (|e) ~^ ctrl[1]});
            rd16(ALM_ADDR_DIAG_STATUS);
            check("diag flags", rd & 16'h0300, {6'h0, e, 8'h00});
        end
        $display("test static done");
        for (int s = 0; s < 6; s++)
        begin
            keff = (spans[s / 2] < 2) ? 1 : spans[s / 2];
            step = 1 + $urandom % 100;
            alm_host_inst.write16(ALM_ADDR_ONE_SAMPLE_COUNT, 16'(spans[s / 2]));
            alm_host_inst.write16(ALM_ADDR_TWO_SAMPLE_COUNT, 16'h0002);
            alm_host_inst.write16(ALM_ADDR_ONE_THRESHOLD, 16'(keff * step - 1 + s % 2));
            alm_host_inst.write16(ALM_ADDR_TWO_THRESHOLD, 16'(2 * step - s % 2));
            alm_host_inst.write16(ALM_ADDR_CONTROL, 16'hc1f0);
            for (int i = 0; i < 6; i++)
                smp({11{16'(i * step)}}, '0);
            check("dynamic flags", {14'h0, flags}, {14'h0, s % 2 == 1, s % 2 == 0});
        end
        $display("test dynamic done");
        give_verdict();
    end
endmodule
